// ===== rtl/overlay_pkg.sv
package overlay_pkg;
  // -------------------------------------------------------------
  // Port addresses and register indices
  // -------------------------------------------------------------
  localparam logic [15:0] PORT_INDEX   = 16'h03CE;
  localparam logic [15:0] PORT_DATA    = 16'h03CF;
  localparam logic [7:0] IDX_OVL_CTRL  = 8'h40;
  localparam logic [7:0] IDX_KEY_VAL   = 8'h41;
  localparam logic [7:0] IDX_KEY_MASK  = 8'h42;
  localparam logic [7:0] IDX_HSTART_HI = 8'h45;
  localparam logic [7:0] IDX_HEND_HI   = 8'h46;
  localparam logic [7:0] IDX_HLOW      = 8'h47;
  localparam logic [7:0] IDX_VSTART_LO = 8'h48;
  localparam logic [7:0] IDX_VEND_LO   = 8'h49;
  localparam logic [7:0] IDX_VHIGH     = 8'h4A;
  localparam logic [7:0] IDX_SYNC_LOCK = 8'h4B;
  localparam logic [7:0] REG_RESET     = 8'h00;
  localparam logic [7:0] HLOW_RW_MASK  = 8'h77;
  localparam logic [7:0] VHIGH_RW_MASK = 8'h0F;

  // -------------------------------------------------------------
  // Field codes
  // -------------------------------------------------------------
  localparam logic [1:0] KEY_EQ = 2'h0;
  localparam logic [1:0] KEY_LT = 2'h1;
  localparam logic [1:0] KEY_GT = 2'h2;
  localparam logic [1:0] SEL_OFF  = 2'h0;
  localparam logic [1:0] SEL_PIN  = 2'h1;
  localparam logic [1:0] SEL_BOTH = 2'h2;
  localparam logic [1:0] SEL_KEY  = 2'h3;
  localparam logic [2:0] MODE_PAL  = 3'h0;
  localparam logic [2:0] MODE_GRAY = 3'h1;
  localparam logic [2:0] MODE_332  = 3'h2;
  localparam logic [2:0] MODE_555  = 3'h4;
  localparam logic [2:0] MODE_565  = 3'h5;
  localparam int FIFO_DEPTH = 32;

  // Overlay control fields, high bit first
  typedef struct packed {
    logic [1:0] key_cmp;
    logic       dac_switch;
    logic [2:0] in_mode;
    logic [1:0] ovl_sel;
  } ovl_ctrl_type;

  // Sync lock control fields
  typedef struct packed {
    logic       vlock;
    logic       hlock;
    logic [2:0] total_adj;
    logic [2:0] sync_adj;
  } sync_ctrl_type;

  // Feature pixel split into colour components
  typedef struct packed {
    logic [5:0] red;
    logic [5:0] green;
    logic [5:0] blue;
  } rgb_type;
endpackage

// ===== rtl/video_overlay_genlock.sv
// Contract
// RQ1: Overlay control sits at index 40h; top two bits choose key comparison.
// RQ2: Key compare code 00 equal, 01 less, 10 greater, 11 reserved.
// RQ3: DAC switch bit makes DAC follow feature mode during overlay only.
// RQ4: Input mode codes: palette, gray, 332, 555, 565; others reserved.
// RQ5: 3:3:2 takes red 7-5, green 4-2, blue 1-0.
// RQ6: 5:5:5 and 5:6:5 split feature lines into red, green, blue.
// RQ7: Narrow connector samples both clock edges in 15/16-bit modes.
// RQ8: Overlay select: off, pin, key and pin, key alone.
// RQ9: Color key value register at index 41h.
// RQ10: Color key mask at 42h; a one bit masks that pixel bit from the compare.
// RQ11: Horizontal start is 45h high bits plus 47h bits 2-0.
// RQ12: Horizontal end is 46h high bits plus 47h bits 6-4.
// RQ13: Vertical start is 48h plus 4Ah bits 1,0.
// RQ14: Vertical end is 49h plus 4Ah bits 3,2; bits 7-4 reserved.
// RQ15: Vertical lock bit turns vsync pin into input and locks timing.
// RQ16: Horizontal lock bit turns hsync pin into input and locks timing.
// RQ17: Software sets both lock bits at 4Bh for full lock.
// RQ18: Total adjust codes alter horizontal total by 0,-4..-1,+1..+3.
// RQ19: Sync adjust delays hsync start after blanking by 0 to 7 clocks.
// RQ20: Index port selects register, data port reaches it.
// RQ21: Inside window with overlay condition, output feature pixel.
// RQ22: Masked bits skip comparison; registers reset to zero.

// ---------------------------------------------------------------
// Feature data FIFO
// ---------------------------------------------------------------
module feature_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic [WIDTH-1:0] i_data,
  input  wire logic             i_valid,
  output logic                  o_ready,
  output logic [WIDTH-1:0]      o_data,
  output logic                  o_valid,
  input  wire logic             i_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_q, wr_d, rd_q, rd_d;
  logic             push, pop;

  // Full and empty from pointer compare
  assign o_ready = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
  assign o_valid = (wr_q != rd_q);
  assign o_data  = mem[rd_q[AW-1:0]];
  assign push    = i_valid && o_ready;
  assign pop     = o_valid && i_ready;

  // Next pointers
  always_comb begin
    wr_d = wr_q + (AW+1)'(push);
    rd_d = rd_q + (AW+1)'(pop);
  end

  // Pointer and storage registers
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
    if (push) begin
      mem[wr_q[AW-1:0]] <= i_data;
    end
  end
endmodule

// ---------------------------------------------------------------
// Overlay, window and genlock logic
// ---------------------------------------------------------------
module video_overlay_genlock
  import overlay_pkg::*;
#(
  parameter int PIX_W   = 16,
  parameter bit NARROW  = 1'b1
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic [15:0] i_io_addr,
  input  wire logic [7:0]  i_io_wdata,
  input  wire logic        i_io_wr,
  input  wire logic        i_io_rd,
  output logic [7:0]       o_io_rdata,
  input  wire logic        i_feature_pixel_clock,
  input  wire logic [15:0] i_feature_data,
  input  wire logic        i_ext_overlay_enable_n,
  input  wire logic        i_gfx_valid,
  input  wire logic [7:0]  i_gfx_pixel,
  input  wire logic [10:0] i_hpos,
  input  wire logic [9:0]  i_vpos,
  input  wire logic        i_hsync_in,
  input  wire logic        i_vsync_in,
  input  wire logic        i_hsync_gen,
  input  wire logic        i_vsync_gen,
  output logic             o_hsync_out,
  output logic             o_hsync_oe,
  output logic             o_vsync_out,
  output logic             o_vsync_oe,
  output logic             o_hlock_ref,
  output logic             o_vlock_ref,
  output logic signed [3:0] o_htotal_adj,
  output logic [2:0]       o_hsync_delay,
  output logic             o_pixel_valid,
  output logic             o_pixel_overlay,
  output logic [15:0]      o_pixel,
  output rgb_type          o_rgb,
  output logic [2:0]       o_dac_mode,
  input  wire logic [2:0]  i_gfx_mode
);
  // -------------------------------------------------------------
  // Register file behind index and data ports
  // -------------------------------------------------------------
  logic [7:0]    index_q, index_d;
  ovl_ctrl_type  ctrl_q, ctrl_d;
  logic [7:0]    key_q, key_d, mask_q, mask_d;
  logic [7:0]    hs_hi_q, hs_hi_d, he_hi_q, he_hi_d, hlow_q, hlow_d;
  logic [7:0]    vs_lo_q, vs_lo_d, ve_lo_q, ve_lo_d, vhigh_q, vhigh_d;
  sync_ctrl_type sync_q, sync_d;
  logic [7:0]    rdata_q, rdata_d;
  logic          data_wr;
  // Data port write strobe
  assign data_wr = i_io_wr && (i_io_addr == PORT_DATA);
  // Next register values
  always_comb begin
    {index_d, ctrl_d, key_d, mask_d, hs_hi_d, he_hi_d} =
      {index_q, ctrl_q, key_q, mask_q, hs_hi_q, he_hi_q};
    {hlow_d, vs_lo_d, ve_lo_d, vhigh_d, sync_d, rdata_d} =
      {hlow_q, vs_lo_q, ve_lo_q, vhigh_q, sync_q, rdata_q};
    if (i_io_wr && (i_io_addr == PORT_INDEX)) begin
      index_d = i_io_wdata; // see RQ20
    end
    if (data_wr) begin
      case (index_q) // see RQ20
        IDX_OVL_CTRL:  ctrl_d  = ovl_ctrl_type'(i_io_wdata); // see RQ1
        IDX_KEY_VAL:   key_d   = i_io_wdata; // see RQ9
        IDX_KEY_MASK:  mask_d  = i_io_wdata; // see RQ10
        IDX_HSTART_HI: hs_hi_d = i_io_wdata; // see RQ11
        IDX_HEND_HI:   he_hi_d = i_io_wdata; // see RQ12
        IDX_HLOW:      hlow_d  = i_io_wdata & HLOW_RW_MASK; // see RQ12
        IDX_VSTART_LO: vs_lo_d = i_io_wdata; // see RQ13
        IDX_VEND_LO:   ve_lo_d = i_io_wdata; // see RQ14
        IDX_VHIGH:     vhigh_d = i_io_wdata & VHIGH_RW_MASK; // see RQ14
        IDX_SYNC_LOCK: sync_d  = sync_ctrl_type'(i_io_wdata);
        default:       ;
      endcase
    end
    if (i_io_rd) begin
      rdata_d = REG_RESET;
      if (i_io_addr == PORT_INDEX) begin
        rdata_d = index_q;
      end else if (i_io_addr == PORT_DATA) begin
        case (index_q)
          IDX_OVL_CTRL:  rdata_d = ctrl_q;
          IDX_KEY_VAL:   rdata_d = key_q;
          IDX_KEY_MASK:  rdata_d = mask_q;
          IDX_HSTART_HI: rdata_d = hs_hi_q;
          IDX_HEND_HI:   rdata_d = he_hi_q;
          IDX_HLOW:      rdata_d = hlow_q;
          IDX_VSTART_LO: rdata_d = vs_lo_q;
          IDX_VEND_LO:   rdata_d = ve_lo_q;
          IDX_VHIGH:     rdata_d = vhigh_q;
          IDX_SYNC_LOCK: rdata_d = sync_q;
          default:       rdata_d = REG_RESET;
        endcase
      end
    end
  end

  // Register storage, all cleared by reset
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      {index_q, ctrl_q, key_q, mask_q, hs_hi_q, he_hi_q} <= '0; // see RQ22
      {hlow_q, vs_lo_q, ve_lo_q, vhigh_q, sync_q, rdata_q} <= '0;
    end else begin
      {index_q, ctrl_q, key_q, mask_q, hs_hi_q, he_hi_q} <=
        {index_d, ctrl_d, key_d, mask_d, hs_hi_d, he_hi_d};
      {hlow_q, vs_lo_q, ve_lo_q, vhigh_q, sync_q, rdata_q} <=
        {hlow_d, vs_lo_d, ve_lo_d, vhigh_d, sync_d, rdata_d};
    end
  end
  assign o_io_rdata = rdata_q;

  // -------------------------------------------------------------
  // Pin synchronisers and feature clock edge detection
  // -------------------------------------------------------------
  logic [2:0]  fclk_q, fclk_d;
  logic [1:0]  evid_q, evid_d, hs_q, hs_d, vs_q, vs_d;
  logic [15:0] fd1_q, fd1_d, fd2_q, fd2_d;
  logic        sample, wide_mode;
  // Shift pins through two flops; third flop only for edge history
  always_comb begin
    fclk_d = {fclk_q[1:0], i_feature_pixel_clock};
    evid_d = {evid_q[0], i_ext_overlay_enable_n};
    hs_d   = {hs_q[0], i_hsync_in};
    vs_d   = {vs_q[0], i_vsync_in};
    fd1_d  = i_feature_data;
    fd2_d  = fd1_q;
  end
  // Synchroniser flops; overlay pin idles high
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      {fclk_q, hs_q, vs_q, fd1_q, fd2_q} <= '0;
      evid_q <= 2'h3;
    end else begin
      {fclk_q, evid_q, hs_q, vs_q} <= {fclk_d, evid_d, hs_d, vs_d};
      {fd1_q, fd2_q} <= {fd1_d, fd2_d};
    end
  end
  assign wide_mode = (ctrl_q.in_mode == MODE_555) ||
                     (ctrl_q.in_mode == MODE_565);
  // Rising edge always; falling edge too for narrow wide-mode data
  assign sample = (fclk_q[1] && !fclk_q[2]) ||
                  (NARROW && wide_mode && !fclk_q[1] && fclk_q[2]); // see RQ7
  // -------------------------------------------------------------
  // Byte pairing and feature FIFO
  // -------------------------------------------------------------
  logic [7:0]  low_q, low_d;
  logic        half_q, half_d;
  logic        f_push, f_ready, f_valid, f_pop;
  logic [15:0] f_word, f_out;
  // Narrow wide-mode pairs low byte then high byte
  always_comb begin
    low_d  = low_q;
    half_d = half_q;
    f_push = 1'b0;
    f_word = fd2_q;
    if (sample) begin
      if (NARROW && wide_mode) begin // see RQ7
        if (!half_q) begin
          low_d  = fd2_q[7:0];
          half_d = 1'b1;
        end else begin
          f_word = {fd2_q[7:0], low_q};
          f_push = 1'b1;
          half_d = 1'b0;
        end
      end else begin
        f_push = 1'b1;
        half_d = 1'b0;
      end
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      low_q  <= '0;
      half_q <= 1'b0;
    end else begin
      low_q  <= low_d;
      half_q <= half_d;
    end
  end
  feature_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_data  (f_word),
    .i_valid (f_push),
    .o_ready (f_ready),
    .o_data  (f_out),
    .o_valid (f_valid),
    .i_ready (f_pop)
  );

  // -------------------------------------------------------------
  // Overlay decision per graphics pixel
  // -------------------------------------------------------------
  logic [10:0] hstart, hend;
  logic [9:0]  vstart, vend;
  logic        in_win, key_hit, pin_hit, cond;
  logic [7:0]  gm, km;
  assign hstart = {hs_hi_q, hlow_q[2:0]}; // see RQ11
  assign hend   = {he_hi_q, hlow_q[6:4]}; // see RQ12
  assign vstart = {vhigh_q[1:0], vs_lo_q}; // see RQ13
  assign vend   = {vhigh_q[3:2], ve_lo_q}; // see RQ14
  assign in_win = (i_hpos >= hstart) && (i_hpos <= hend) &&
                  (i_vpos >= vstart) && (i_vpos <= vend);
  assign gm = i_gfx_pixel & ~mask_q; // see RQ22
  assign km = key_q & ~mask_q; // see RQ10
  // Key comparison and overlay source choice
  always_comb begin
    case (ctrl_q.key_cmp) // see RQ2
      KEY_EQ:  key_hit = (gm == km);
      KEY_LT:  key_hit = (gm < km);
      KEY_GT:  key_hit = (gm > km);
      default: key_hit = 1'b0;
    endcase
    pin_hit = !evid_q[1];
    case (ctrl_q.ovl_sel) // see RQ8
      SEL_PIN:  cond = pin_hit;
      SEL_BOTH: cond = pin_hit && key_hit;
      SEL_KEY:  cond = key_hit;
      default:  cond = 1'b0;
    endcase
    cond  = cond && in_win; // see RQ21
    f_pop = i_gfx_valid && cond && f_valid;
  end

  // -------------------------------------------------------------
  // Pixel output and colour split
  // -------------------------------------------------------------
  logic        pv_q, pv_d, po_q, po_d;
  logic [15:0] pix_q, pix_d;
  rgb_type     rgb_q, rgb_d;
  logic [2:0]  dmode_q, dmode_d;
  // Choose feature or graphics pixel and the DAC mode
  always_comb begin
    pv_d    = i_gfx_valid;
    po_d    = i_gfx_valid && cond;
    pix_d   = po_d ? f_out : {8'h00, i_gfx_pixel}; // see RQ21
    rgb_d   = '0;
    case (ctrl_q.in_mode) // see RQ4
      MODE_332: rgb_d = {3'h0, f_out[7:5], 3'h0, f_out[4:2],
                         4'h0, f_out[1:0]}; // see RQ5
      MODE_555: rgb_d = {1'b0, f_out[14:10], 1'b0, f_out[9:5],
                         1'b0, f_out[4:0]}; // see RQ6
      MODE_565: rgb_d = {f_out[15:10], 1'b0, f_out[9:5],
                         1'b0, f_out[4:0]}; // see RQ6
      default: rgb_d = '0; // Palette and gray carry no split
    endcase
    dmode_d = (ctrl_q.dac_switch && po_d) ? ctrl_q.in_mode
                                           : i_gfx_mode; // see RQ3
  end
  // Output registers
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      {pv_q, po_q, pix_q, rgb_q, dmode_q} <= '0;
    end else begin
      {pv_q, po_q, pix_q, rgb_q, dmode_q} <=
        {pv_d, po_d, pix_d, rgb_d, dmode_d};
    end
  end
  assign o_pixel_valid   = pv_q;
  assign o_pixel_overlay = po_q;
  assign o_pixel         = pix_q;
  assign o_rgb           = rgb_q;
  assign o_dac_mode      = dmode_q;
  // -------------------------------------------------------------
  // Genlock pins and timing adjustment
  // -------------------------------------------------------------
  // Lock bits turn the sync pins around and feed the timing generator
  always_comb begin
    o_vsync_oe    = !sync_q.vlock; // see RQ15
    o_hsync_oe    = !sync_q.hlock; // see RQ16
    o_vsync_out   = i_vsync_gen;
    o_hsync_out   = i_hsync_gen;
    o_vlock_ref   = sync_q.vlock && vs_q[1]; // see RQ15
    o_hlock_ref   = sync_q.hlock && hs_q[1]; // see RQ16
    o_hsync_delay = sync_q.hlock ? sync_q.sync_adj : 3'h0; // see RQ19
    case (sync_q.hlock ? sync_q.total_adj : 3'h0) // see RQ18
      3'h1:    o_htotal_adj = -4'sd4;
      3'h2:    o_htotal_adj = -4'sd3;
      3'h3:    o_htotal_adj = -4'sd2;
      3'h4:    o_htotal_adj = -4'sd1;
      3'h5:    o_htotal_adj = 4'sd1;
      3'h6:    o_htotal_adj = 4'sd2;
      3'h7:    o_htotal_adj = 4'sd3;
      default: o_htotal_adj = 4'sd0;
    endcase
  end
endmodule

// ===== testbench/feature_source_model.sv
module feature_source_model (
  output logic        o_clk,
  output logic [15:0] o_data
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------
  // Feature source
  // ----------------------------
  // Clock rests low between frames
  initial begin
    o_clk = 1'b0;
    o_data = 16'h0000;
  end

  // One word; dual splits it into low byte on rise, high byte on fall
  task automatic send(input logic [15:0] w, input logic dual);
    o_data = dual ? {~w[15:8], w[7:0]} : w;
    #31.25;
    o_clk = 1'b1;
    #31.25;
    if (dual) o_data = {~w[7:0], w[15:8]};
    #31.25;
    o_clk = 1'b0;
    #15.625;
    o_data = ~o_data; // Released lines stop showing the word
    #15.625;
  endtask
endmodule

// ===== testbench/video_overlay_genlock_props.sv
module video_overlay_genlock_props
  import overlay_pkg::*;
(
  input wire logic              i_clk,
  input wire logic              i_rst,
  input wire logic [15:0]       i_io_addr,
  input wire logic              i_io_rd,
  input wire logic [7:0]        o_io_rdata,
  input wire logic              i_gfx_valid,
  input wire logic [7:0]        i_gfx_pixel,
  input wire logic [2:0]        i_gfx_mode,
  input wire logic              o_hsync_oe,
  input wire logic              o_vsync_oe,
  input wire logic              o_hlock_ref,
  input wire logic              o_vlock_ref,
  input wire logic signed [3:0] o_htotal_adj,
  input wire logic [2:0]        o_hsync_delay,
  input wire logic              o_pixel_valid,
  input wire logic              o_pixel_overlay,
  input wire logic [15:0]       o_pixel,
  input wire logic [2:0]        o_dac_mode
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // ----------------------------
  // Port, genlock and pixel relations
  // ----------------------------
  property p_rd_foreign;
    i_io_rd && i_io_addr != PORT_INDEX && i_io_addr != PORT_DATA
      |=> o_io_rdata == 8'h00;
  endproperty
  a_rd_foreign: assert property (p_rd_foreign)
    else $error("foreign port read not zero");
  property p_rd_hold;
    !i_io_rd |=> $stable(o_io_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data changed without a read");
  property p_hlock_oe;
    o_hlock_ref |-> !o_hsync_oe;
  endproperty
  a_hlock_oe: assert property (p_hlock_oe)
    else $error("hsync driven while locked");
  property p_vlock_oe;
    o_vlock_ref |-> !o_vsync_oe;
  endproperty
  a_vlock_oe: assert property (p_vlock_oe)
    else $error("vsync driven while locked");
  property p_adj_idle;
    o_hsync_oe |-> o_htotal_adj == 4'sh0 && o_hsync_delay == 3'h0;
  endproperty
  a_adj_idle: assert property (p_adj_idle)
    else $error("adjust active without lock");
  property p_pix_valid;
    i_gfx_valid |=> o_pixel_valid;
  endproperty
  a_pix_valid: assert property (p_pix_valid)
    else $error("pixel lost");
  property p_ovl_valid;
    o_pixel_overlay |-> o_pixel_valid;
  endproperty
  a_ovl_valid: assert property (p_ovl_valid)
    else $error("overlay flag on idle pixel");
  property p_gfx_pass;
    o_pixel_valid && !o_pixel_overlay
      |-> o_pixel == {8'h00, $past(i_gfx_pixel)};
  endproperty
  a_gfx_pass: assert property (p_gfx_pass)
    else $error("graphics pixel altered");
  property p_dac_gfx;
    o_pixel_valid && !o_pixel_overlay |-> o_dac_mode == $past(i_gfx_mode);
  endproperty
  a_dac_gfx: assert property (p_dac_gfx)
    else $error("dac left graphics mode");

  c_overlay: cover property (o_pixel_valid && o_pixel_overlay);
  c_locks: cover property (o_hlock_ref && o_vlock_ref);
  c_read: cover property (i_io_rd ##1 o_io_rdata != 8'h00);
endmodule

bind video_overlay_genlock video_overlay_genlock_props u_props (
  .i_clk(i_clk), .i_rst(i_rst), .i_io_addr(i_io_addr),
  .i_io_rd(i_io_rd), .o_io_rdata(o_io_rdata), .i_gfx_valid(i_gfx_valid),
  .i_gfx_pixel(i_gfx_pixel), .i_gfx_mode(i_gfx_mode),
  .o_hsync_oe(o_hsync_oe), .o_vsync_oe(o_vsync_oe),
  .o_hlock_ref(o_hlock_ref), .o_vlock_ref(o_vlock_ref),
  .o_htotal_adj(o_htotal_adj), .o_hsync_delay(o_hsync_delay),
  .o_pixel_valid(o_pixel_valid), .o_pixel_overlay(o_pixel_overlay),
  .o_pixel(o_pixel), .o_dac_mode(o_dac_mode)
);

// ===== testbench/testbench.sv
module testbench
  import overlay_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic              i_clk, i_rst, i_io_wr, i_io_rd, i_gfx_valid;
  logic              i_ext_overlay_enable_n, i_hsync_in, i_vsync_in;
  logic              feat_clk, o_hsync_oe, o_vsync_oe, o_hlock_ref;
  logic              o_vlock_ref, o_pixel_valid, o_pixel_overlay;
  logic [15:0]       i_io_addr, feat_data, o_pixel;
  logic [10:0]       i_hpos;
  logic [9:0]        i_vpos;
  logic [7:0]        i_io_wdata, i_gfx_pixel, o_io_rdata;
  logic [2:0]        i_gfx_mode, o_hsync_delay, o_dac_mode;
  logic signed [3:0] o_htotal_adj;
  rgb_type           o_rgb;
  int                error_cnt, checked;

  feature_source_model u_feature_source_model (
    .o_clk(feat_clk), .o_data(feat_data));

  video_overlay_genlock #(.NARROW(1'b1)) u_video_overlay_genlock (
    .i_clk(i_clk), .i_rst(i_rst), .i_io_addr(i_io_addr),
    .i_io_wdata(i_io_wdata), .i_io_wr(i_io_wr), .i_io_rd(i_io_rd),
    .o_io_rdata(o_io_rdata), .i_feature_pixel_clock(feat_clk),
    .i_feature_data(feat_data),
    .i_ext_overlay_enable_n(i_ext_overlay_enable_n),
    .i_gfx_valid(i_gfx_valid), .i_gfx_pixel(i_gfx_pixel),
    .i_hpos(i_hpos), .i_vpos(i_vpos), .i_hsync_in(i_hsync_in),
    .i_vsync_in(i_vsync_in), .i_hsync_gen(1'b0), .i_vsync_gen(1'b0),
    .o_hsync_out(), .o_hsync_oe(o_hsync_oe), .o_vsync_out(),
    .o_vsync_oe(o_vsync_oe), .o_hlock_ref(o_hlock_ref),
    .o_vlock_ref(o_vlock_ref), .o_htotal_adj(o_htotal_adj),
    .o_hsync_delay(o_hsync_delay), .o_pixel_valid(o_pixel_valid),
    .o_pixel_overlay(o_pixel_overlay), .o_pixel(o_pixel), .o_rgb(o_rgb),
    .o_dac_mode(o_dac_mode), .i_gfx_mode(i_gfx_mode));

  // ----------------------------
  // Shared tasks
  // ----------------------------
  task automatic chk(input string n, input logic [15:0] e, g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask

  // One port cycle: a write when w is set, a read otherwise
  task automatic io(input logic [15:0] a, input logic [7:0] d,
                    input logic w);
    @(posedge i_clk) #1;
    i_io_addr = a;
    i_io_wdata = d;
    i_io_wr = w;
    i_io_rd = !w;
    @(posedge i_clk) #1;
    i_io_wr = 1'b0;
    i_io_rd = 1'b0;
  endtask

  task automatic wr(input logic [7:0] x, d);
    io(PORT_INDEX, x, 1'b1);
    io(PORT_DATA, d, 1'b1);
  endtask

  task automatic rd(input logic [7:0] x, e);
    io(PORT_INDEX, x, 1'b1);
    io(PORT_DATA, 8'h00, 1'b0);
    chk("rdata", {8'h00, e}, {8'h00, o_io_rdata});
  endtask

  task automatic ctl(input logic [1:0] k, input logic d,
                     input logic [2:0] m, input logic [1:0] s);
    ovl_ctrl_type c;
    c = '{key_cmp: k, dac_switch: d, in_mode: m, ovl_sel: s};
    wr(IDX_OVL_CTRL, c);
  endtask

  // Pin change plus its synchroniser delay
  task automatic pin(input logic n);
    @(posedge i_clk) #1;
    i_ext_overlay_enable_n = n;
    repeat (3) @(posedge i_clk);
  endtask

  // One graphics pixel, then its overlay flag and dac mode
  task automatic px(input logic [10:0] h, input logic [9:0] v,
                    input logic [7:0] g, input logic ov,
                    input logic [2:0] dm);
    @(posedge i_clk) #1;
    i_hpos = h;
    i_vpos = v;
    i_gfx_pixel = g;
    i_gfx_valid = 1'b1;
    @(posedge i_clk) #1;
    i_gfx_valid = 1'b0;
    chk("overlay", {15'h0, ov}, {15'h0, o_pixel_overlay});
    chk("dac_mode", {13'h0, dm}, {13'h0, o_dac_mode});
  endtask

  // ----------------------------
  // Scenarios
  // ----------------------------
  task automatic t_regs();
    logic [7:0] ix [10] = '{IDX_OVL_CTRL, IDX_KEY_VAL, IDX_KEY_MASK,
      IDX_HSTART_HI, IDX_HEND_HI, IDX_HLOW, IDX_VSTART_LO, IDX_VEND_LO,
      IDX_VHIGH, IDX_SYNC_LOCK};
    logic [7:0] m;
    foreach (ix[i]) rd(ix[i], REG_RESET);
    foreach (ix[i]) begin
      m = ix[i] == IDX_HLOW ? HLOW_RW_MASK :
          ix[i] == IDX_VHIGH ? VHIGH_RW_MASK : 8'hFF;
      wr(ix[i], 8'hFF);
      rd(ix[i], m);
      wr(ix[i], 8'h00);
    end
    io(16'h03C0, 8'h00, 1'b0);
    chk("foreign", 16'h0000, {8'h00, o_io_rdata});
    wr(8'h44, 8'hFF);
    rd(8'h44, 8'h00);
    $display("t_regs done");
  endtask

  // Fill the buffer past full, then drain it through pin overlay
  task automatic t_fifo();
    ctl(KEY_EQ, 1'b0, MODE_332, SEL_PIN);
    for (int k = 0; k < 34; k++)
      u_feature_source_model.send(16'h1000 + 16'(k), 1'b0);
    pin(1'b1);
    px(11'h000, 10'h000, 8'h33, 1'b0, MODE_GRAY);
    chk("pixel", 16'h0033, o_pixel);
    pin(1'b0);
    for (int k = 0; k < FIFO_DEPTH; k++) begin
      px(11'h000, 10'h000, 8'h33, 1'b1, MODE_GRAY);
      chk("pixel", 16'h1000 + 16'(k), o_pixel);
      chk("blue", 16'(k % 4), {10'h0, o_rgb.blue});
      chk("green", 16'(k / 4), {10'h0, o_rgb.green});
    end
    $display("t_fifo done");
  endtask

  task automatic t_key();
    logic [7:0] pv [4] = '{8'h3F, 8'h40, 8'h4F, 8'h50};
    logic [7:0] msk, a, b;
    logic       e;
    wr(IDX_KEY_VAL, 8'h40);
    for (int m = 0; m < 2; m++) begin
      msk = m ? 8'h0F : 8'h00;
      wr(IDX_KEY_MASK, msk);
      for (int c = 0; c < 4; c++) begin
        ctl(2'(c), 1'b1, MODE_565, SEL_KEY);
        foreach (pv[j]) begin
          a = pv[j] & ~msk;
          b = 8'h40 & ~msk;
          e = c == 0 ? a == b : c == 1 ? a < b : c == 2 ? a > b : 1'b0;
          px(11'h000, 10'h000, pv[j], e, e ? MODE_565 : MODE_GRAY);
        end
      end
    end
    for (int s = 0; s < 4; s++)
      for (int n = 0; n < 2; n++) begin
        ctl(KEY_EQ, 1'b0, MODE_PAL, 2'(s));
        pin(n[0]);
        e = s == 3 || (s != 0 && n == 0);
        px(11'h000, 10'h000, 8'h40, e, MODE_GRAY);
      end
    $display("t_key done");
  endtask

  task automatic t_dual();
    ctl(KEY_EQ, 1'b0, MODE_565, SEL_PIN);
    pin(1'b0);
    u_feature_source_model.send(16'hA5C3, 1'b1);
    u_feature_source_model.send(16'h5A3C, 1'b1);
    px(11'h000, 10'h000, 8'h00, 1'b1, MODE_GRAY);
    chk("pixel", 16'hA5C3, o_pixel);
    chk("red", 16'h0029, {10'h0, o_rgb.red});
    chk("green", 16'h000E, {10'h0, o_rgb.green});
    px(11'h000, 10'h000, 8'h00, 1'b1, MODE_GRAY);
    chk("pixel", 16'h5A3C, o_pixel);
    chk("red", 16'h0016, {10'h0, o_rgb.red});
    $display("t_dual done");
  endtask

  task automatic t_window();
    logic [10:0] h [7] = '{11'h012, 11'h013, 11'h01D, 11'h01E, 11'h013,
                           11'h013, 11'h01D};
    logic [9:0]  v [7] = '{10'h105, 10'h105, 10'h205, 10'h105, 10'h104,
                           10'h206, 10'h206};
    logic        e [7] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
    wr(IDX_HSTART_HI, 8'h02);
    wr(IDX_HEND_HI, 8'h03);
    wr(IDX_HLOW, 8'h53);
    wr(IDX_VSTART_LO, 8'h05);
    wr(IDX_VEND_LO, 8'h05);
    wr(IDX_VHIGH, 8'h09);
    foreach (h[i]) px(h[i], v[i], 8'h11, e[i], MODE_GRAY);
    $display("t_window done");
  endtask

  task automatic t_lock();
    int adj [8] = '{0, -4, -3, -2, -1, 1, 2, 3};
    @(posedge i_clk) #1;
    {i_hsync_in, i_vsync_in} = 2'h3;
    for (int k = 0; k < 8; k++) begin
      wr(IDX_SYNC_LOCK, {2'b01, 3'(k), 3'(k)});
      chk("htotal", {12'h0, 4'(adj[k])}, {12'h0, o_htotal_adj});
      chk("hdelay", {13'h0, 3'(k)}, {13'h0, o_hsync_delay});
      chk("oe", 16'h0001, {14'h0, o_hsync_oe, o_vsync_oe});
      chk("ref", 16'h0002, {14'h0, o_hlock_ref, o_vlock_ref});
    end
    wr(IDX_SYNC_LOCK, 8'hC0);
    chk("oe", 16'h0000, {14'h0, o_hsync_oe, o_vsync_oe});
    chk("ref", 16'h0003, {14'h0, o_hlock_ref, o_vlock_ref});
    wr(IDX_SYNC_LOCK, 8'h00);
    chk("oe", 16'h0003, {14'h0, o_hsync_oe, o_vsync_oe});
    $display("t_lock done");
  endtask

  task automatic test_done();
    $display("checked %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Clock generation
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  // Watchdog far beyond the expected run
  initial begin
    #300us;
    error_cnt++;
    $display("watchdog expired");
    test_done();
  end

  // Main sequence
  initial begin
    i_rst = 1'b1;
    {i_io_wr, i_io_rd, i_gfx_valid, i_hsync_in, i_vsync_in} = 5'h00;
    i_ext_overlay_enable_n = 1'b1;
    i_io_addr = 16'h0000;
    i_io_wdata = 8'h00;
    i_gfx_pixel = 8'h00;
    i_hpos = 11'h000;
    i_vpos = 10'h000;
    i_gfx_mode = MODE_GRAY;
    repeat (8) @(posedge i_clk);
    #1;
    i_rst = 1'b0;
    t_regs();
    t_fifo();
    t_key();
    t_dual();
    t_window();
    t_lock();
    test_done();
  end
endmodule
